// *** core/ctp_cfg.svh ***
// register indices, field positions, reset values and counts of the clock tree
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH
// register indices; byte address is four times the index
`define CTP_IDX_SRC       8'h85
`define CTP_IDX_RELOAD    8'h97
`define CTP_IDX_CFG0      8'h8f
`define CTP_IDX_CFG1      8'haf
`define CTP_IDX_PLL       8'ha3
`define CTP_IDX_CONV      8'hbf
`define CTP_IDX_CARD      8'hf0
`define CTP_IDX_ALT       8'hf1
`define CTP_IDX_PWR       8'hf2
`define CTP_IDX_STAT      8'hf3
// field positions
`define CTP_CFG0_DBL      0
`define CTP_CFG0_T0       1
`define CTP_CFG0_T1       2
`define CTP_CFG0_SI       4
`define CTP_CFG0_WD       6
`define CTP_CFG1_SPI      0
`define CTP_PLL_LOCK      0
`define CTP_PLL_EN        1
`define CTP_PLL_USB       2
`define CTP_CARD_SRC      7
// reset values
`define CTP_RELOAD_RST    4'hf
`define CTP_DIV_RST       6'h00
// usb clock: pll edges per half period of the usb clock
`define CTP_USB_HALF      3'h1
`endif

// *** core/ctp_pkg.sv ***
// types of the clock tree prescalers
package ctp_pkg;
  // power reduction modes, one-hot
  typedef enum logic [2:0] {
    PWR_RUN   = 3'b001,
    PWR_IDLE  = 3'b010,
    PWR_DOWN  = 3'b100
  } ctp_pwr_t;

  // the whole state of the clock tree
  typedef struct packed {
    logic [2:0]  xt_sy;      // [0] first sync, [1] second sync, [2] previous
    logic [2:0]  pl_sy;
    logic [1:0]  lk_sy;
    logic        src_sel;
    logic [3:0]  reload;
    logic        dbl;
    logic [4:0]  per_dbl;    // t0, t1, uart, watchdog, spi
    logic [5:0]  card_div;
    logic        card_src;
    logic [1:0]  alt_sel;
    logic [3:0]  conv_div;
    logic        usb_src;
    logic        pll_en;
    ctp_pwr_t    pwr;
    logic        act_src;
    logic        act_dbl;
    logic [3:0]  act_reload;
    logic [3:0]  idle_cnt;
    logic        idle_lvl;
    logic        idle_prev;
    logic        half_lvl;
    logic [5:0]  act_card;
    logic [5:0]  card_cnt;
    logic        card_lvl;
    logic [1:0]  act_alt;
    logic [2:0]  alt_cnt;
    logic [3:0]  act_conv;
    logic [3:0]  conv_cnt;
    logic        conv_lvl;
    logic        act_usb;
    logic [2:0]  usb_cnt;
    logic        usb_lvl;
    logic [10:0] gate_en;
    logic [10:0] clk_out;
    logic        dph_wr;
    logic [7:0]  dph_idx;
    logic [31:0] rdata;
    logic        rdy;
  } ctp_state_t;
endpackage

// *** core/ctp_clock_tree.sv ***
// clock tree: source select, four prescalers, speed modes, gating and register slave
`timescale 1ns/1ps
`include "ctp_cfg.svh"
module ctp_clock_tree (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // clock sources, asynchronous to i_clk
  input  wire logic        i_crystal_input,
  input  wire logic        i_pll_output_clock,
  input  wire logic        i_pll_locked_flag,
  // generated clocks
  output logic             o_core_clock,
  output logic             o_idle_clock,
  output logic             o_timer0_clock,
  output logic             o_timer1_clock,
  output logic             o_serial_port_clock,
  output logic             o_watchdog_clock,
  output logic             o_serial_periph_clock,
  output logic             o_card_clock,
  output logic             o_alt_card_clock,
  output logic             o_converter_clock,
  output logic             o_usb_side_clock,
  // pll control
  output logic             o_pll_enable
);

  ctp_pkg::ctp_state_t st_ff;
  ctp_pkg::ctp_state_t nxt_st;

  // derived levels and edges of the synchronised sources
  logic        xt_lvl;
  logic        xt_rise;
  logic        pl_lvl;
  logic        pl_rise;
  logic        src_lvl;
  logic        src_rise;
  logic [3:0]  idle_term;
  logic        idle_raw;
  logic        idle_rise;
  logic [4:0]  per_raw;
  logic        card_src_lvl;
  logic        card_rise;
  logic        card_raw;
  logic        alt_raw;
  logic        usb_raw;
  logic [10:0] raw;
  logic [10:0] gate_req;
  logic        addr_ok;

  // the second flop of each synchroniser is read here, and the previous flop as well for the rising edges
  assign xt_lvl    = st_ff.xt_sy[1];
  assign xt_rise   = st_ff.xt_sy[1] & ~st_ff.xt_sy[2];
  assign pl_lvl    = st_ff.pl_sy[1];
  assign pl_rise   = st_ff.pl_sy[1] & ~st_ff.pl_sy[2];
  assign src_lvl   = st_ff.act_src ? pl_lvl : xt_lvl;
  assign src_rise  = st_ff.act_src ? pl_rise : xt_rise;
  assign idle_term = 4'hf - st_ff.act_reload;
  // double speed bypasses the main prescaler with the crystal level
  assign idle_raw  = st_ff.act_dbl ? xt_lvl : st_ff.idle_lvl;
  assign idle_rise = idle_raw & ~st_ff.idle_prev;

  // peripheral clocks: idle clock, or half of it when double speed is on and bit clear
  for (genvar gi = 0; gi < 5; gi++) begin : g_per
    assign per_raw[gi] = (st_ff.act_dbl && !st_ff.per_dbl[gi]) ? st_ff.half_lvl : idle_raw;
  end

  // card clock source is independent of the core path
  assign card_src_lvl = st_ff.card_src ? xt_lvl : pl_lvl;
  assign card_rise    = st_ff.card_src ? xt_rise : pl_rise;
  assign card_raw     = (st_ff.act_card == 6'h00) ? card_src_lvl : st_ff.card_lvl;

  // alternate card clock taps the ripple-free counter bits
  always_comb begin
    unique case (st_ff.act_alt)
      2'h0:    alt_raw = idle_raw;
      2'h1:    alt_raw = st_ff.alt_cnt[0];
      2'h2:    alt_raw = st_ff.alt_cnt[1];
      default: alt_raw = st_ff.alt_cnt[2];
    endcase
  end

  assign usb_raw = st_ff.act_usb ? xt_lvl : st_ff.usb_lvl;
  // bit 0 core up to bit 10 usb; main, card, alternate and converter prescalers feed them,
  // the usb divider sits beside them and is not one of the four
  assign raw     = {usb_raw, st_ff.conv_lvl, alt_raw, card_raw, per_raw, idle_raw, idle_raw};

  // power modes: idle stops the core only, power down stops everything
  assign gate_req = st_ff.pwr == ctp_pkg::PWR_RUN  ? 11'h7ff :
                    st_ff.pwr == ctp_pkg::PWR_IDLE ? 11'h7fe : 11'h000;

  assign addr_ok = (i_haddr[31:10] == 22'h0) && (i_haddr[1:0] == 2'h0);

  // register read mux; reserved bits read as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0;
    unique case (idx)
      `CTP_IDX_SRC:    v[0]   = st_ff.src_sel;
      `CTP_IDX_RELOAD: v[3:0] = st_ff.reload;
      `CTP_IDX_CFG0: begin
        v[`CTP_CFG0_DBL] = st_ff.dbl;
        v[`CTP_CFG0_T0]  = st_ff.per_dbl[0];
        v[`CTP_CFG0_T1]  = st_ff.per_dbl[1];
        v[`CTP_CFG0_SI]  = st_ff.per_dbl[2];
        v[`CTP_CFG0_WD]  = st_ff.per_dbl[3];
      end
      `CTP_IDX_CFG1:   v[`CTP_CFG1_SPI] = st_ff.per_dbl[4];
      `CTP_IDX_PLL: begin
        v[`CTP_PLL_LOCK] = st_ff.lk_sy[1];
        v[`CTP_PLL_EN]   = st_ff.pll_en;
        v[`CTP_PLL_USB]  = st_ff.usb_src;
      end
      `CTP_IDX_CONV:   v[3:0] = st_ff.conv_div;
      `CTP_IDX_CARD: begin
        v[5:0]           = st_ff.card_div;
        v[`CTP_CARD_SRC] = st_ff.card_src;
      end
      `CTP_IDX_ALT:    v[1:0] = st_ff.alt_sel;
      `CTP_IDX_PWR:    v[2:0] = st_ff.pwr;
      // status: active settings and the forbidden pll plus double speed request
      `CTP_IDX_STAT:   v[7:0] = {st_ff.act_reload, st_ff.src_sel & st_ff.dbl, st_ff.act_dbl, st_ff.act_src,
                                 st_ff.lk_sy[1]};
      default:         v = 32'h0;
    endcase
    return v;
  endfunction

  // next state of everything
  always_comb begin
    nxt_st = st_ff;
    nxt_st.xt_sy = {st_ff.xt_sy[1:0], i_crystal_input};
    nxt_st.pl_sy = {st_ff.pl_sy[1:0], i_pll_output_clock};
    nxt_st.lk_sy = {st_ff.lk_sy[0], i_pll_locked_flag};
    nxt_st.rdy   = 1'b1;

    // register writes land in the data phase
    if (st_ff.dph_wr) begin
      unique case (st_ff.dph_idx)
        `CTP_IDX_SRC:    nxt_st.src_sel = i_hwdata[0];
        `CTP_IDX_RELOAD: nxt_st.reload  = i_hwdata[3:0];
        `CTP_IDX_CFG0: begin
          nxt_st.dbl        = i_hwdata[`CTP_CFG0_DBL];
          nxt_st.per_dbl[0] = i_hwdata[`CTP_CFG0_T0];
          nxt_st.per_dbl[1] = i_hwdata[`CTP_CFG0_T1];
          nxt_st.per_dbl[2] = i_hwdata[`CTP_CFG0_SI];
          nxt_st.per_dbl[3] = i_hwdata[`CTP_CFG0_WD];
          // raising double speed moves every peripheral to double speed too
          if (i_hwdata[`CTP_CFG0_DBL] && !st_ff.dbl) begin
            nxt_st.per_dbl = 5'h1f;
          end
        end
        `CTP_IDX_CFG1:   nxt_st.per_dbl[4] = i_hwdata[`CTP_CFG1_SPI];
        `CTP_IDX_PLL: begin
          nxt_st.pll_en  = i_hwdata[`CTP_PLL_EN];
          nxt_st.usb_src = i_hwdata[`CTP_PLL_USB];
        end
        `CTP_IDX_CONV:   nxt_st.conv_div = i_hwdata[3:0];
        `CTP_IDX_CARD: begin
          nxt_st.card_div = i_hwdata[5:0];
          nxt_st.card_src = i_hwdata[`CTP_CARD_SRC];
        end
        `CTP_IDX_ALT:    nxt_st.alt_sel = i_hwdata[1:0];
        `CTP_IDX_PWR: begin
          // a code that is not one-hot is ignored
          if (i_hwdata[2:0] == 3'b001 || i_hwdata[2:0] == 3'b010 || i_hwdata[2:0] == 3'b100) begin
            nxt_st.pwr = ctp_pkg::ctp_pwr_t'(i_hwdata[2:0]);
          end
        end
        default: ;
      endcase
    end

    // address phase: reads are answered from a flop in the data phase; the next address
    // is taken in that same data phase, so a read right behind a write returns the old value
    nxt_st.dph_wr = 1'b0;
    if (i_hsel && i_htrans[1] && i_hready) begin
      nxt_st.dph_wr  = i_hwrite && addr_ok;
      nxt_st.dph_idx = addr_ok ? i_haddr[9:2] : 8'h00;
      nxt_st.rdata   = (i_hwrite || !addr_ok) ? 32'h0 : rd_mux(i_haddr[9:2]);
    end

    // main prescaler: toggles every 16-reload source edges
    if (st_ff.act_dbl) begin
      nxt_st.idle_cnt = 4'h0;
      nxt_st.idle_lvl = 1'b0;
    end else if (src_rise) begin
      if (st_ff.idle_cnt == idle_term) begin
        nxt_st.idle_cnt = 4'h0;
        nxt_st.idle_lvl = ~st_ff.idle_lvl;
      end else begin
        nxt_st.idle_cnt = st_ff.idle_cnt + 4'h1;
      end
    end
    // settings switch only while the idle clock is low, so no runt appears;
    // pll with double speed is refused, the prescaler stays in the path
    if ((st_ff.act_dbl ? !xt_lvl : (!st_ff.idle_lvl && st_ff.idle_cnt == 4'h0)) && !src_rise && !src_lvl) begin
      nxt_st.act_src    = st_ff.src_sel;
      nxt_st.act_dbl    = st_ff.dbl && !st_ff.src_sel;
      nxt_st.act_reload = st_ff.reload;
    end

    // half idle clock and the alternate card counter
    nxt_st.idle_prev = idle_raw;
    if (idle_rise) begin
      nxt_st.half_lvl = ~st_ff.half_lvl;
      nxt_st.alt_cnt  = st_ff.alt_cnt + 3'h1;
    end
    if (st_ff.alt_cnt == 3'h0 && !idle_raw) begin
      nxt_st.act_alt = st_ff.alt_sel;
    end

    // card prescaler: divides by field+1, high for the first half
    if (st_ff.act_card == 6'h00) begin
      nxt_st.card_cnt = 6'h00;
      nxt_st.card_lvl = 1'b0;
      if (!card_src_lvl) begin
        nxt_st.act_card = st_ff.card_div;
      end
    end else if (card_rise) begin
      if (st_ff.card_cnt == st_ff.act_card) begin
        nxt_st.card_cnt = 6'h00;
        nxt_st.card_lvl = 1'b1;
        nxt_st.act_card = st_ff.card_div;
        if (st_ff.card_div == 6'h00) begin
          nxt_st.card_lvl = 1'b0;
        end
      end else begin
        nxt_st.card_cnt = st_ff.card_cnt + 6'h01;
        nxt_st.card_lvl = ({1'b0, st_ff.card_cnt} + 7'h01) < (({1'b0, st_ff.act_card} + 7'h02) >> 1);
      end
    end

    // converter prescaler: toggles every field+1 crystal edges, even duty
    if (xt_rise) begin
      if (st_ff.conv_cnt == st_ff.act_conv) begin
        nxt_st.conv_cnt = 4'h0;
        nxt_st.conv_lvl = ~st_ff.conv_lvl;
        if (st_ff.conv_lvl) begin
          nxt_st.act_conv = st_ff.conv_div;
        end
      end else begin
        nxt_st.conv_cnt = st_ff.conv_cnt + 4'h1;
      end
    end

    // usb clock divider on the pll
    if (pl_rise) begin
      if (st_ff.usb_cnt == `CTP_USB_HALF - 3'h1) begin
        nxt_st.usb_cnt = 3'h0;
        nxt_st.usb_lvl = ~st_ff.usb_lvl;
      end else begin
        nxt_st.usb_cnt = st_ff.usb_cnt + 3'h1;
      end
    end
    if (!xt_lvl && !st_ff.usb_lvl) begin
      nxt_st.act_usb = st_ff.usb_src;
    end

    // gates open or close only while both clock and output are low
    for (int i = 0; i < 11; i++) begin
      if (!st_ff.clk_out[i] && !raw[i]) begin
        nxt_st.gate_en[i] = gate_req[i];
      end
      nxt_st.clk_out[i] = raw[i] & nxt_st.gate_en[i];
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff            <= '0;
      st_ff.reload     <= `CTP_RELOAD_RST;
      st_ff.act_reload <= `CTP_RELOAD_RST;
      st_ff.card_div   <= `CTP_DIV_RST;
      st_ff.pwr        <= ctp_pkg::PWR_RUN;
      st_ff.rdy        <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign o_hrdata              = st_ff.rdata;
  assign o_hreadyout           = st_ff.rdy;
  assign o_hresp               = 1'b0 & st_ff.rdy;
  assign o_core_clock          = st_ff.clk_out[0];
  assign o_idle_clock          = st_ff.clk_out[1];
  assign o_timer0_clock        = st_ff.clk_out[2];
  assign o_timer1_clock        = st_ff.clk_out[3];
  assign o_serial_port_clock   = st_ff.clk_out[4];
  assign o_watchdog_clock      = st_ff.clk_out[5];
  assign o_serial_periph_clock = st_ff.clk_out[6];
  assign o_card_clock          = st_ff.clk_out[7];
  assign o_alt_card_clock      = st_ff.clk_out[8];
  assign o_converter_clock     = st_ff.clk_out[9];
  assign o_usb_side_clock      = st_ff.clk_out[10];
  assign o_pll_enable          = st_ff.pll_en;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_gate_opens;
    $rose(st_ff.gate_en[1]);
  endsequence
  sequence s_quiet_edge;
    !st_ff.clk_out[1] ##1 !st_ff.clk_out[1] || raw[1];
  endsequence

  reset_single_speed_a: assert property ($fell(i_srst) |-> st_ff.reload == 4'hf && !st_ff.act_dbl && !st_ff.act_src)
    else $error("main prescaler not at divide by two after reset");
  pll_no_double_a: assert property (st_ff.act_src |-> !st_ff.act_dbl)
    else $error("pll source running in double speed");
  single_ignores_per_a: assert property (!st_ff.act_dbl |-> per_raw == {5{idle_raw}})
    else $error("peripheral clock differs from idle clock in single speed");
  // the timer0 pin must follow the half-rate divider one flop later while its gate is open
  half_per_clock_a: assert property (st_ff.act_dbl && !st_ff.per_dbl[0] && st_ff.gate_en[2]
                                     && st_ff.pwr != ctp_pkg::PWR_DOWN
                                     |=> o_timer0_clock == $past(st_ff.half_lvl))
    else $error("timer0 clock not at half idle rate");
  idle_divide_a: assert property (!st_ff.act_dbl && src_rise && st_ff.idle_cnt == idle_term
                                  |=> st_ff.idle_lvl != $past(st_ff.idle_lvl) && st_ff.idle_cnt == 4'h0)
    else $error("main prescaler missed its terminal count");
  double_bypass_a: assert property (st_ff.act_dbl |-> idle_raw == xt_lvl && st_ff.idle_cnt == 4'h0)
    else $error("main prescaler not bypassed in double speed");
  conv_toggle_a: assert property (xt_rise && st_ff.conv_cnt == st_ff.act_conv
                                  |=> st_ff.conv_lvl == !$past(st_ff.conv_lvl))
    else $error("converter clock did not toggle at its count");
  gate_no_runt_a: assert property (s_gate_opens |-> s_quiet_edge)
    else $error("idle clock gate opened during a high phase");
  power_down_a: assert property (st_ff.pwr == ctp_pkg::PWR_DOWN && !st_ff.clk_out[0] && !raw[0]
                                 |=> !st_ff.gate_en[0])
    else $error("core clock gate still open in power down");

endmodule // ctp_clock_tree

// *** test/ctp_clk_meter.sv ***
// consumer-side model: measures period and high time of one generated clock
`timescale 1ns/1ps
module ctp_clk_meter (
  // clock and clear
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  // watched clock level
  input  wire logic        i_sig,
  // last whole period, its high time and rising edges seen, in i_clk cycles
  output logic      [15:0] o_period,
  output logic      [15:0] o_high,
  output logic      [3:0]  o_edges
);
  logic        prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;

  // every rise is seen one sample late, the same for each, so periods stay exact
  always_ff @(posedge i_clk) begin
    prev <= i_sig;
    if (i_clr) begin
      cnt <= 16'h0000;
      hcnt <= 16'h0000;
      o_edges <= 4'h0;
    end else if (i_sig && !prev) begin
      o_period <= cnt;
      o_high <= hcnt;
      cnt <= 16'h0001;
      hcnt <= 16'h0001;
      if (o_edges != 4'hf) o_edges <= o_edges + 4'h1;
    end else begin
      cnt <= cnt + 16'h0001;
      hcnt <= hcnt + {15'h0, i_sig};
    end
  end
endmodule // ctp_clk_meter

// *** test/ctp_clock_tree_tb.sv ***
// self-checking bench of the clock tree prescalers
`timescale 1ns/1ps
`include "ctp_cfg.svh"
module ctp_clock_tree_tb;
  localparam int K_CORE = 0, K_IDLE = 1, K_T0 = 2, K_T1 = 3, K_SPI = 6;
  localparam int K_CARD = 7, K_ALT = 8, K_CONV = 9, K_USB = 10;
  logic        i_clk;
  logic        i_srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        xtal;
  logic        pll;
  logic        lock;
  logic        pll_en;
  logic [10:0] clks;
  logic [3:0]  sel;
  logic        clr;
  logic [15:0] per;
  logic [15:0] hi;
  logic [3:0]  edges;
  int          n_fail;
  int          check_count;

  // 100 MHz system clock
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  // sources: 80 ns crystal, 60 ns pll, phases unrelated to i_clk
  initial begin
    xtal = 1'b0;
    #3;
    forever #40 xtal = ~xtal;
  end
  initial begin
    pll = 1'b0;
    #7;
    forever #30 pll = ~pll;
  end

  ctp_clock_tree uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_crystal_input(xtal), .i_pll_output_clock(pll), .i_pll_locked_flag(lock),
    .o_core_clock(clks[0]), .o_idle_clock(clks[1]), .o_timer0_clock(clks[2]),
    .o_timer1_clock(clks[3]), .o_serial_port_clock(clks[4]), .o_watchdog_clock(clks[5]),
    .o_serial_periph_clock(clks[6]), .o_card_clock(clks[7]), .o_alt_card_clock(clks[8]),
    .o_converter_clock(clks[9]), .o_usb_side_clock(clks[10]), .o_pll_enable(pll_en));

  ctp_clk_meter meter (.i_clk(i_clk), .i_clr(clr), .i_sig(clks[sel]),
    .o_period(per), .o_high(hi), .o_edges(edges));

  task automatic bad(input string msg);
    n_fail++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one single transfer; every phase is held until hready is sampled high
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge i_clk); // one idle cycle after the previous data phase
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, idx, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e, input string msg);
    logic [31:0] r;
    ahb(1'b0, idx, 32'h0, r);
    check_count++;
    if ((r & m) !== e || hresp !== 1'b0) bad(msg);
  endtask

  // settle past the safe switch point, then time whole periods; p of 0 means held low
  task automatic chk_clk(input int k, input int p, input int h, input string msg);
    int n;
    sel <= 4'(k);
    repeat (300) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    n = 0;
    while (edges < 4'h3 && n < 1500) begin
      @(posedge i_clk);
      n++;
    end
    check_count++;
    if (p == 0) begin
      if (edges !== 4'h0 || clks[k] !== 1'b0) bad(msg);
    end else if (per !== 16'(p) || (h > 0 && hi !== 16'(h))) bad(msg);
  endtask

  task automatic t_reset;
    rd_chk(`CTP_IDX_SRC, 32'h1, 32'h0, "source reset");
    rd_chk(`CTP_IDX_RELOAD, 32'hf, 32'hf, "reload reset");
    rd_chk(`CTP_IDX_CFG0, 32'h57, 32'h0, "config0 reset");
    rd_chk(`CTP_IDX_STAT, 32'hfe, 32'hf0, "status reset");
    rd_chk(`CTP_IDX_PLL, 32'h7, 32'h1, "pll reg reset");
    rd_chk(8'h00, 32'hffffffff, 32'h0, "unmapped read");
    chk_clk(K_CORE, 16, 8, "core single speed");
    chk_clk(K_IDLE, 16, 0, "idle single speed");
    for (int k = K_T0; k <= K_SPI; k++) chk_clk(k, 16, 0, "peripheral single speed");
    $display("test reset done");
  endtask

  task automatic t_double;
    wr(`CTP_IDX_CFG0, 32'h2);
    chk_clk(K_T0, 16, 0, "timer0 bit ignored");
    wr(`CTP_IDX_CFG0, 32'h1);
    rd_chk(`CTP_IDX_CFG0, 32'h57, 32'h57, "peripheral bits follow");
    chk_clk(K_CORE, 8, 4, "core double speed");
    chk_clk(K_IDLE, 8, 0, "idle equals crystal");
    for (int k = K_T0; k <= K_SPI; k++) chk_clk(k, 8, 0, "peripheral double speed");
    wr(`CTP_IDX_CFG0, 32'h55);
    chk_clk(K_T0, 16, 0, "timer0 half idle");
    chk_clk(K_T1, 8, 0, "timer1 stays double");
    wr(`CTP_IDX_CFG1, 32'h0);
    chk_clk(K_SPI, 16, 0, "spi half idle");
    wr(`CTP_IDX_CFG0, 32'h0);
    chk_clk(K_CORE, 16, 0, "core back single");
    $display("test double done");
  endtask

  task automatic t_reload;
    wr(`CTP_IDX_RELOAD, 32'he);
    chk_clk(K_IDLE, 32, 0, "idle reload e");
    rd_chk(`CTP_IDX_STAT, 32'hf0, 32'he0, "active reload");
    wr(`CTP_IDX_RELOAD, 32'hf);
    chk_clk(K_CORE, 16, 0, "core reload f");
    $display("test reload done");
  endtask

  task automatic t_pll;
    wr(`CTP_IDX_SRC, 32'h1); // double speed is clear when the pll takes over
    chk_clk(K_IDLE, 12, 0, "idle from pll");
    wr(`CTP_IDX_CFG0, 32'h1);
    chk_clk(K_CORE, 12, 0, "double refused on pll");
    rd_chk(`CTP_IDX_STAT, 32'he, 32'ha, "refusal flagged");
    wr(`CTP_IDX_CFG0, 32'h0);
    wr(`CTP_IDX_SRC, 32'h0);
    chk_clk(K_IDLE, 16, 0, "idle back on crystal");
    $display("test pll done");
  endtask

  task automatic t_prescalers;
    chk_clk(K_CARD, 6, 0, "card pll pass");
    wr(`CTP_IDX_CARD, 32'h82); // core/card ratio 1.5, card near 4 MHz
    chk_clk(K_CARD, 24, 0, "card crystal div3");
    wr(`CTP_IDX_CARD, 32'h3f);
    chk_clk(K_CARD, 384, 0, "card pll div64");
    wr(`CTP_IDX_CARD, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(`CTP_IDX_ALT, 32'(s));
      chk_clk(K_ALT, 16 << s, 0, "alternate card ratio");
    end
    chk_clk(K_CONV, 16, 8, "converter div2");
    wr(`CTP_IDX_CONV, 32'h1);
    chk_clk(K_CONV, 32, 16, "converter div4");
    wr(`CTP_IDX_CONV, 32'hf);
    chk_clk(K_CONV, 256, 128, "converter div32");
    $display("test prescalers done");
  endtask

  task automatic t_usb_power;
    chk_clk(K_USB, 12, 0, "usb from pll");
    wr(`CTP_IDX_PLL, 32'h6);
    chk_clk(K_USB, 8, 0, "usb from crystal");
    check_count++;
    if (pll_en !== 1'b1) bad("pll enable");
    wr(`CTP_IDX_PLL, 32'h0);
    wr(`CTP_IDX_PWR, 32'h2);
    chk_clk(K_CORE, 0, 0, "core gated in idle");
    chk_clk(K_IDLE, 16, 0, "idle runs in idle");
    wr(`CTP_IDX_PWR, 32'h4);
    chk_clk(K_IDLE, 0, 0, "idle gated in power down");
    chk_clk(K_CONV, 0, 0, "converter gated");
    wr(`CTP_IDX_PWR, 32'h1);
    chk_clk(K_CORE, 16, 0, "core runs again");
    $display("test usb power done");
  endtask

  // main sequence: inputs known at time zero, reset held four cycles
  initial begin
    i_srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lock = 1'b1;
    sel = 4'h0;
    clr = 1'b1;
    n_fail = 0;
    check_count = 0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset;
    t_double;
    t_reload;
    t_pll;
    t_prescalers;
    t_usb_power;
    test_done;
  end

  // about 50 checks of at most 1800 cycles each fit just inside this span of 100000 cycles
  initial begin
    #1_000_000;
    bad("watchdog expired");
    test_done;
  end
endmodule // ctp_clock_tree_tb
